// ### src/pcd_regs.vh
`ifndef PCD_REGS_VH
`define PCD_REGS_VH
// clock and line timing
`define PCD_CLK_HZ 25000000
`define PCD_HOLD_US 2500
// hold count: 2.5 ms at 25 MHz, microseconds times whole cycles per microsecond, no rounding up
`define PCD_HOLD_CYC ((`PCD_HOLD_US * (`PCD_CLK_HZ / 1000000)))
// pwm period 1 ms, split into 16 slots
`define PCD_PWM_HZ 1000
`define PCD_PWM_SLOT_CYC ((`PCD_CLK_HZ / `PCD_PWM_HZ) / 16)
// led code limits
`define PCD_LED_MAX_CODE 5'h1F
`define PCD_LED_FULL_CODE 5'h01
`define PCD_LED_PWM_FIRST 5'h0C
`define PCD_LED_FINE_FIRST 5'h16
// regulator count limits
`define PCD_REG_MAX_CODE 4'hF
`define PCD_REG_OFF_CODE 4'h0
`endif

// ### src/pcd_line_timer.v
`timescale 1ns/1ps
`default_nettype none
// per-line pulse counter and hold / shutdown timer
module pcd_line_timer #(
   parameter HOLD_CYC = 62500,
   parameter CW = 5,
   parameter [CW-1:0] MAXC = 5'h1F,
   parameter SATURATE = 0
) (
   input wire mclk_in,
   input wire srst_in,
   input wire ce_in,
   input wire line_in,
   output reg [CW-1:0] count_out,
   output reg sat_out,
   output reg high_done_out,
   output reg low_done_out
);
   reg line_d_r; // previous synchronised level
   reg [31:0] tmr_r; // cycles since last edge
   wire rise = line_in & ~line_d_r;
   wire edge_w = line_in ^ line_d_r;
   // restart the interval timer at every edge, hold at the limit
   always @(posedge mclk_in) begin
      if (srst_in) begin
         line_d_r <= 1'b1;
         tmr_r <= 32'h00000000;
         count_out <= {CW{1'b0}};
         sat_out <= 1'b0;
         high_done_out <= 1'b0;
         low_done_out <= 1'b0;
      end else if (ce_in) begin
         line_d_r <= line_in;
         high_done_out <= 1'b0;
         low_done_out <= 1'b0;
         if (edge_w) begin
            tmr_r <= 32'h00000000;
         end else if (tmr_r < HOLD_CYC) begin
            tmr_r <= tmr_r + 32'h00000001;
            // one pulse when the interval completes
            if (tmr_r == HOLD_CYC - 1) begin
               high_done_out <= line_in;
               low_done_out <= ~line_in;
            end
         end
         if (rise) begin
            // count on rising edge of each low pulse
            if (count_out == MAXC) begin
               if (SATURATE != 0) begin
                  sat_out <= 1'b1;
               end else begin
                  count_out <= {{(CW-1){1'b0}}, 1'b1};
               end
            end else begin
               count_out <= count_out + {{(CW-1){1'b0}}, 1'b1};
            end
         end else if (high_done_out | low_done_out) begin
            // a fresh train starts from zero after any latch or shutdown
            count_out <= {CW{1'b0}};
            sat_out <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ### src/pcd_pwm.v
`timescale 1ns/1ps
`default_nettype none
// 1 kHz pwm with 16 slots of duty resolution
module pcd_pwm #(
   parameter SLOT_CYC = 1562
) (
   input wire mclk_in,
   input wire srst_in,
   input wire ce_in,
   input wire [4:0] duty_in,
   output reg pwm_out
);
   reg [15:0] div_r; // slot prescaler
   reg [3:0] slot_r; // slot within the period
   // free running period counter; the pwm compares slot to duty
   always @(posedge mclk_in) begin
      if (srst_in) begin
         div_r <= 16'h0000;
         slot_r <= 4'h0;
         pwm_out <= 1'b1;
      end else if (ce_in) begin
         if (div_r == SLOT_CYC - 1) begin
            div_r <= 16'h0000;
            slot_r <= slot_r + 4'h1;
         end else begin
            div_r <= div_r + 16'h0001;
         end
         pwm_out <= ({1'b0, slot_r} < duty_in);
      end
   end
endmodule
`default_nettype wire

// ### src/pcd_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "pcd_regs.vh"
module pcd_ctrl #(
   parameter HOLD_CYC = `PCD_HOLD_CYC,
   parameter SLOT_CYC = `PCD_PWM_SLOT_CYC
) (
   input wire mclk_in,
   input wire srst_in,
   input wire ce_in,
   input wire led_ctrl_line_in,
   input wire regulator_ctrl_line_in,
   input wire thermal_recover_in,
   output reg led_enable_out,
   output reg [4:0] led_code_out,
   output reg led_pwm_out,
   output reg [3:0] led_duty_out,
   output reg reg_enable_out,
   output reg [3:0] reg_sel_out,
   output reg [5:0] first_regulator_mv100_out,
   output reg [5:0] second_regulator_mv100_out
);
   // two-flop synchronisers for the pins
   // reset to the idle high level so no false edge is counted after reset
   reg led_s1_r, led_s2_r, reg_s1_r, reg_s2_r;
   always @(posedge mclk_in) begin
      if (srst_in) begin
         led_s1_r <= 1'b1;
         led_s2_r <= 1'b1;
         reg_s1_r <= 1'b1;
         reg_s2_r <= 1'b1;
      end else if (ce_in) begin
         led_s1_r <= led_ctrl_line_in;
         led_s2_r <= led_s1_r;
         reg_s1_r <= regulator_ctrl_line_in;
         reg_s2_r <= reg_s1_r;
      end
   end

   // independent timer per line
   wire [4:0] led_cnt;
   wire led_hi_done, led_lo_done;
   pcd_line_timer #(.HOLD_CYC(HOLD_CYC), .CW(5), .MAXC(`PCD_LED_MAX_CODE), .SATURATE(0))
   u_led (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .ce_in(ce_in),
      .line_in(led_s2_r),
      .count_out(led_cnt),
      .sat_out(),
      .high_done_out(led_hi_done),
      .low_done_out(led_lo_done)
   );
   wire [3:0] reg_cnt;
   wire reg_sat, reg_hi_done, reg_lo_done;
   pcd_line_timer #(.HOLD_CYC(HOLD_CYC), .CW(4), .MAXC(`PCD_REG_MAX_CODE), .SATURATE(1))
   u_reg (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .ce_in(ce_in),
      .line_in(reg_s2_r),
      .count_out(reg_cnt),
      .sat_out(reg_sat),
      .high_done_out(reg_hi_done),
      .low_done_out(reg_lo_done)
   );

   // duty in sixteenths for a current code
   function [4:0] duty_of;
      input [4:0] code;
      begin
         if (code < `PCD_LED_PWM_FIRST) begin
            duty_of = 5'h10; // full on above 6.4mA
         end else if (code < `PCD_LED_FINE_FIRST) begin
            // 16,14,12,10 repeating from 6.4mA to 1.4mA
            duty_of = 5'h10 - {2'b00, code[1:0], 1'b0};
         end else if (code < 5'h19) begin
            // 1.2, 1.0, 0.8mA give 12, 10, 8
            duty_of = 5'h0C - {code[3:0] - 4'h6, 1'b0};
         end else begin
            // 0.7 down to 0.1mA give 7 down to 1
            duty_of = 5'h1F - code + 5'h01;
         end
      end
   endfunction

   // regulator pair in units of 0.1V, first in high half
   function [11:0] pair_of;
      input [3:0] sel;
      begin
         case (sel)
            4'h1: pair_of = {6'd28, 6'd12};
            4'h2: pair_of = {6'd33, 6'd12};
            4'h3: pair_of = {6'd28, 6'd15};
            4'h4: pair_of = {6'd33, 6'd15};
            4'h5: pair_of = {6'd12, 6'd18};
            4'h6: pair_of = {6'd18, 6'd18};
            4'h7: pair_of = {6'd28, 6'd18};
            4'h8: pair_of = {6'd33, 6'd18};
            4'h9: pair_of = {6'd28, 6'd28};
            4'hA: pair_of = {6'd0, 6'd15};
            4'hB: pair_of = {6'd0, 6'd18};
            4'hC: pair_of = {6'd0, 6'd28};
            4'hD: pair_of = {6'd18, 6'd0};
            4'hE: pair_of = {6'd28, 6'd0};
            4'hF: pair_of = {6'd33, 6'd0};
            default: pair_of = {6'd0, 6'd0};
         endcase
      end
   endfunction

   // pwm engine, duty taken from the latched code
   wire pwm_w;
   wire [4:0] duty_w = duty_of(led_code_out);
   pcd_pwm #(.SLOT_CYC(SLOT_CYC)) u_pwm (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .ce_in(ce_in),
      .duty_in(duty_w),
      .pwm_out(pwm_w)
   );

   // the wake pulse is the first rising edge seen while in shutdown
   reg reg_wake_r; // first edge already consumed
   reg reg_d_r; // previous synchronised regulator level
   wire reg_rise = reg_s2_r & ~reg_d_r;
   reg led_seen_r; // startup level already judged
   reg [1:0] settle_r; // waits until the synchronisers show the real pin level

   // led latch: hold high latches count, long low shuts down
   always @(posedge mclk_in) begin
      if (srst_in) begin
         led_enable_out <= 1'b0;
         led_code_out <= `PCD_LED_FULL_CODE;
         led_pwm_out <= 1'b0;
         led_duty_out <= 4'h0;
         led_seen_r <= 1'b0;
         settle_r <= 2'h0;
      end else if (ce_in) begin
         if (settle_r != 2'h3) begin
            settle_r <= settle_r + 2'h1;
         end
         led_pwm_out <= led_enable_out & pwm_w;
         led_duty_out <= duty_w[3:0];
         if (thermal_recover_in) begin
            led_code_out <= `PCD_LED_FULL_CODE;
         end else if (!led_seen_r && (settle_r == 2'h3) && led_s2_r) begin
            // line already high at start: full brightness at once
            led_seen_r <= 1'b1;
            led_enable_out <= 1'b1;
            led_code_out <= `PCD_LED_FULL_CODE;
         end else if (led_hi_done) begin
            led_seen_r <= 1'b1;
            led_enable_out <= 1'b1;
            // no pulses means plain on at full current
            led_code_out <= (led_cnt == 5'h00) ? `PCD_LED_FULL_CODE : led_cnt;
         end else if (led_lo_done) begin
            led_seen_r <= 1'b1;
            led_enable_out <= 1'b0;
         end
      end
   end

   // regulator latch: wake edge, saturation, shutdown
   always @(posedge mclk_in) begin
      if (srst_in) begin
         reg_d_r <= 1'b1;
         reg_wake_r <= 1'b0;
         reg_enable_out <= 1'b0;
         reg_sel_out <= `PCD_REG_OFF_CODE;
         first_regulator_mv100_out <= 6'h00;
         second_regulator_mv100_out <= 6'h00;
      end else if (ce_in) begin
         reg_d_r <= reg_s2_r;
         {first_regulator_mv100_out, second_regulator_mv100_out} <= reg_enable_out ?
            pair_of(reg_sel_out) : 12'h000;
         if (thermal_recover_in) begin
            reg_sel_out <= `PCD_REG_OFF_CODE;
         end else if (reg_lo_done) begin
            reg_enable_out <= 1'b0;
            reg_wake_r <= 1'b0;
         end else if (reg_hi_done) begin
            if (reg_enable_out | reg_wake_r) begin
               reg_enable_out <= 1'b1;
               // running: every edge counts, no wake pulse
               reg_sel_out <= reg_sat ? `PCD_REG_OFF_CODE :
                  (reg_enable_out ? reg_cnt : reg_cnt - 4'h1);
            end
            reg_wake_r <= 1'b0;
         end else if (reg_rise && !reg_enable_out) begin
            reg_wake_r <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ### bench/pcd_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
// pin-level watch on both pulse lines and their latched results
module pcd_ctrl_sva #(
   parameter HOLD_CYC = 50
) (
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic led_ctrl_line_in,
   input wire logic regulator_ctrl_line_in,
   input wire logic thermal_recover_in,
   input wire logic led_enable_out,
   input wire logic [4:0] led_code_out,
   input wire logic led_pwm_out,
   input wire logic [3:0] led_duty_out,
   input wire logic reg_enable_out,
   input wire logic [3:0] reg_sel_out,
   input wire logic [5:0] first_regulator_mv100_out,
   input wire logic [5:0] second_regulator_mv100_out
);
   // slack covers the input synchroniser and the latch stage
   localparam int LIM = HOLD_CYC + 8;
   logic [15:0] led_lo_r; // cycles the led line has been low
   logic [15:0] reg_lo_r; // cycles the regulator line has been low
   // low-run counters saturate so a long park never wraps to zero
   always @(posedge mclk_in) begin
      if (srst_in || led_ctrl_line_in) led_lo_r <= 16'h0000;
      else if (!(&led_lo_r)) led_lo_r <= led_lo_r + 16'h0001;
      if (srst_in || regulator_ctrl_line_in) reg_lo_r <= 16'h0000;
      else if (!(&reg_lo_r)) reg_lo_r <= reg_lo_r + 16'h0001;
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (srst_in);
   // pair three latched, then one settled cycle
   sequence pair_set;
      reg_enable_out && reg_sel_out == 4'h3 ##1 reg_enable_out && $stable(reg_sel_out);
   endsequence
   code_range_a: assert property (led_code_out != 5'h00)
      else $error("led code left its range");
   pwm_gate_a: assert property ((!led_enable_out)[*2] |-> !led_pwm_out)
      else $error("pwm active while sinks are off");
   full_duty_a: assert property (led_enable_out && led_code_out <= 5'h0C &&
      $stable(led_code_out) |-> led_duty_out == 4'h0) else $error("high code not at full duty");
   pair_three_a: assert property (pair_set |-> first_regulator_mv100_out == 6'h1C &&
      second_regulator_mv100_out == 6'h0F) else $error("pair three voltages wrong");
   volts_off_a: assert property ((!reg_enable_out)[*2] |-> first_regulator_mv100_out == 6'h00 &&
      second_regulator_mv100_out == 6'h00) else $error("voltage while in shutdown");
   thermal_rst_a: assert property (thermal_recover_in |=> led_code_out == 5'h01 &&
      reg_sel_out == 4'h0) else $error("thermal recovery did not restore defaults");
   led_shut_a: assert property (led_lo_r > LIM |-> !led_enable_out)
      else $error("led sinks on after long low");
   reg_shut_a: assert property (reg_lo_r > LIM |-> !reg_enable_out)
      else $error("regulators on after long low");
   led_rise_a: assert property ($rose(led_enable_out) |-> led_ctrl_line_in)
      else $error("sinks enabled while line low");
endmodule
bind pcd_ctrl pcd_ctrl_sva #(.HOLD_CYC(HOLD_CYC)) u_pcd_ctrl_sva (
   .mclk_in(mclk_in), .srst_in(srst_in), .led_ctrl_line_in(led_ctrl_line_in),
   .regulator_ctrl_line_in(regulator_ctrl_line_in), .thermal_recover_in(thermal_recover_in),
   .led_enable_out(led_enable_out), .led_code_out(led_code_out), .led_pwm_out(led_pwm_out),
   .led_duty_out(led_duty_out), .reg_enable_out(reg_enable_out), .reg_sel_out(reg_sel_out),
   .first_regulator_mv100_out(first_regulator_mv100_out),
   .second_regulator_mv100_out(second_regulator_mv100_out));
`default_nettype wire

// ### bench/pcd_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side: drives both pulse lines, idle high, changes at falling edges
module pcd_host #(
   parameter HOLD_CYC = 50
) (
   input wire logic mclk_in,
   output logic led_line_out,
   output logic reg_line_out
);
   initial begin
      led_line_out = 1'b1;
      reg_line_out = 1'b1;
   end
   // which: 0 led line, 1 regulator line
   task automatic drive(input logic which, input logic v);
      if (which) reg_line_out = v;
      else led_line_out = v;
   endtask
   // n low pulses of 13 cycles (520 ns, inside the legal width), then the hold
   task automatic train(input logic which, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge mclk_in) drive(which, 1'b0);
         repeat (13) @(negedge mclk_in);
         drive(which, 1'b1);
         repeat (12) @(negedge mclk_in);
      end
      // full new train each time, then high past the hold so latching is done
      @(negedge mclk_in) drive(which, 1'b1);
      repeat (HOLD_CYC + 12) @(negedge mclk_in);
   endtask
   // long low leaves the line parked low for shutdown
   task automatic park(input logic which);
      @(negedge mclk_in) drive(which, 1'b0);
      repeat (HOLD_CYC + 12) @(negedge mclk_in);
   endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// sequences of host trains with the expected latched results
module tb_top;
   localparam int HOLD = 50; // shortened hold so runs stay brief
   logic mclk_in = 1'b0;
   logic srst_in = 1'b1;
   logic thermal_recover_in = 1'b0;
   logic led_line, reg_line, led_enable_out, led_pwm_out, reg_enable_out;
   logic [4:0] led_code_out;
   logic [3:0] led_duty_out, reg_sel_out;
   logic [5:0] first_v, second_v;
   int n_mismatch = 0;
   int total_checks = 0;
   int nt[5] = '{12, 13, 22, 31, 33}; // pulse counts, 33 wraps to 2
   logic [4:0] ct[5] = '{5'h0C, 5'h0D, 5'h16, 5'h1F, 5'h02};
   logic [3:0] dt[5] = '{4'h0, 4'hE, 4'hC, 4'h1, 4'h0}; // sixteen reads as zero
   initial begin
      forever #20 mclk_in = ~mclk_in;
   end
   pcd_host #(.HOLD_CYC(HOLD)) u_pcd_host (.mclk_in(mclk_in), .led_line_out(led_line),
      .reg_line_out(reg_line));
   pcd_ctrl #(.HOLD_CYC(HOLD), .SLOT_CYC(4)) u_pcd_ctrl (.mclk_in(mclk_in),
      .srst_in(srst_in), .ce_in(1'b1), .led_ctrl_line_in(led_line),
      .regulator_ctrl_line_in(reg_line), .thermal_recover_in(thermal_recover_in),
      .led_enable_out(led_enable_out), .led_code_out(led_code_out),
      .led_pwm_out(led_pwm_out), .led_duty_out(led_duty_out),
      .reg_enable_out(reg_enable_out), .reg_sel_out(reg_sel_out),
      .first_regulator_mv100_out(first_v), .second_regulator_mv100_out(second_v));
   // one compare for every latched value, four-state exact on the low 8 bits only
   task automatic chk(input logic [7:0] act, input logic [7:0] exp);
      total_checks++;
      if (act !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t exp=%h act=%h", $time, exp, act);
      end
   endtask
   task automatic close_out;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // whole run needs about 4400 cycles
   initial begin
      repeat (20000) @(posedge mclk_in);
      n_mismatch++;
      close_out();
   end
   initial begin
      repeat (4) @(negedge mclk_in);
      srst_in = 1'b0;
      repeat (10) @(negedge mclk_in);
      chk(led_enable_out, 8'h01);
      chk(led_code_out, 8'h01);
      for (int i = 0; i < 5; i++) begin
         u_pcd_host.train(1'b0, nt[i]);
         chk(led_code_out, ct[i]);
         chk(led_duty_out, dt[i]);
         chk(reg_sel_out, 8'h00);
      end
      u_pcd_host.park(1'b0);
      chk(led_enable_out, 8'h00);
      u_pcd_host.train(1'b0, 0);
      chk(led_code_out, 8'h01);
      chk(led_enable_out, 8'h01);
      u_pcd_host.park(1'b1);
      chk(reg_enable_out, 8'h00);
      chk(led_enable_out, 8'h01);
      // wake pulse plus three counted
      u_pcd_host.train(1'b1, 4);
      chk(reg_sel_out, 8'h03);
      chk(reg_enable_out, 8'h01);
      chk({first_v, second_v}, {6'h1C, 6'h0F});
      // no wake when running; 17 saturates to off
      u_pcd_host.train(1'b1, 17);
      chk(reg_sel_out, 8'h00);
      chk(reg_enable_out, 8'h01);
      u_pcd_host.train(1'b1, 1);
      chk(reg_sel_out, 8'h01);
      chk({first_v, second_v}, {6'h1C, 6'h0C});
      u_pcd_host.train(1'b0, 5);
      chk(led_code_out, 8'h05);
      @(negedge mclk_in) thermal_recover_in = 1'b1;
      @(negedge mclk_in) thermal_recover_in = 1'b0;
      @(negedge mclk_in);
      chk(led_code_out, 8'h01);
      chk(reg_sel_out, 8'h00);
      close_out();
   end
endmodule
`default_nettype wire
